// [src/framer_ctrl_map.svh]
// register offsets, field positions, reset values for the framer control
`ifndef FRAMER_CTRL_MAP_SVH
`define FRAMER_CTRL_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FRAMER_CONTROL_OFFSET 8'h10
`define ERROR_INSERT_CONTROL_OFFSET 8'h18

// ****************************************
// reset values
// ****************************************
`define FRAMER_CONTROL_RESET 16'h0000
`define ERROR_INSERT_CONTROL_RESET 8'h00

// ****************************************
// framer_control fields
// ****************************************
`define FC_SEND_ALARM_INDICATION 0
`define FC_SEND_REMOTE_ALARM 1
`define FC_TRANSPARENT_PASS_THROUGH 2
`define FC_NATIONAL_BIT_SOURCE_LO 3
`define FC_NATIONAL_BIT_SOURCE_HI 4
`define FC_SEND_IDLE_SIGNAL 5
`define FC_LINE_LOOP_ENABLE 6
`define FC_DIAG_LOOP_ENABLE 7
`define FC_CODE_VIOLATION_COUNT_SEL 8
`define FC_FRAME_ERR_COUNT_SEL_LO 9
`define FC_FRAME_ERR_COUNT_SEL_HI 10
`define FC_COUNT_DURING_LOF 11
`define FC_AUTO_BLOCK_ERROR_DEFEAT 12
`define FC_MANUAL_BLOCK_ERROR_VALUE 13
`define FC_PAYLOAD_LOOP_ENABLE 14
`define FC_WRITABLE_MASK 16'h7fff

// ****************************************
// error_insert_control fields
// ****************************************
`define EI_BIPOLAR_VIOLATION_INSERT 0
`define EI_EXCESS_ZERO_INSERT 1
`define EI_MANUAL_INSERT_MODE 7

// ****************************************
// national bit source codes
// ****************************************
`define NAT_FORCE_ONE 2'b00
`define NAT_FROM_HDLC 2'b01
`define NAT_FROM_FEAC 2'b10
`define NAT_FORCE_ZERO 2'b11

// ****************************************
// frame error counter selections
// ****************************************
`define FE_COUNT_LOF 2'b00
`define FE_COUNT_ILLEGAL_E3 2'b11

// ****************************************
// zero run lengths and codeword spans
// ****************************************
`define ZERO_RUN_T3 3
`define ZERO_RUN_E3 4
`define RUN_OF_ONES 3

`endif

// [src/framer_ctrl_pkg.sv]
// types shared by the framer control block and its line encoder
package framer_ctrl_pkg;

  // ****************************************
  // position of a bit within the frame
  // ****************************************
  typedef enum logic [3:0] {
    cls_info,
    cls_f,
    cls_m,
    cls_p,
    cls_x,
    cls_c3,
    cls_c4,
    cls_c,
    cls_fas,
    cls_rai,
    cls_nat
  } bit_class_type;

  typedef struct packed {
    logic data;
    bit_class_type cls;
  } tx_bit_type;

  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
  } line_type;

  // ****************************************
  // encoder symbol codes
  // ****************************************
  typedef enum logic [2:0] {
    sym_zero,
    sym_held,
    sym_one,
    sym_cstart,
    sym_viol,
    sym_bpv
  } symbol_type;

endpackage

// [src/bipolar_encoder.sv]
// b3zs / hdb3 line encoder with single error insertion
`timescale 1ns/1ps
`default_nettype none
`include "framer_ctrl_map.svh"

module bipolar_encoder
  import framer_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic step,
  input wire logic data,
  input wire logic e3_mode,
  input wire logic unipolar_mode,
  input wire logic bpv_arm,
  input wire logic exz_arm,
  output logic pos,
  output logic neg
);

  symbol_type buf_q [0:3];
  symbol_type buf_d [0:3];
  logic bpv_pend_q;
  logic exz_pend_q;
  logic last_pos_q;
  logic parity_q;
  logic zero_win;
  logic ones_win;
  logic use_bpv;
  logic use_exz;
  logic mark;
  logic mark_pos;
  symbol_type out_sym;

  // ****************************************
  // window check on the newest symbols
  // ****************************************
  always_comb begin
    buf_d[0] = data ? sym_one : sym_zero;
    buf_d[1] = buf_q[0];
    buf_d[2] = buf_q[1];
    buf_d[3] = buf_q[2];
    zero_win = (buf_d[0] == sym_zero) && (buf_d[1] == sym_zero) &&
               (buf_d[2] == sym_zero) &&
               (!e3_mode || buf_d[3] == sym_zero);
    ones_win = (buf_d[0] == sym_one) && (buf_d[1] == sym_one) &&
               (buf_d[2] == sym_one);
    use_bpv = bpv_pend_q && ones_win && !unipolar_mode;
    use_exz = exz_pend_q && zero_win && !unipolar_mode;
    if (use_bpv) begin
      buf_d[0] = sym_bpv;
    end else if (zero_win && !unipolar_mode) begin
      buf_d[0] = use_exz ? sym_held : sym_viol;
      buf_d[1] = sym_held;
      if (e3_mode) begin
        buf_d[2] = sym_held;
        buf_d[3] = use_exz ? sym_held : sym_cstart;
      end else begin
        buf_d[2] = use_exz ? sym_held : sym_cstart;
      end
    end
  end

  // ****************************************
  // symbol pipeline
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        buf_q[i] <= sym_zero;
      end
    end else if (ce && step) begin
      for (int i = 0; i < 4; i++) begin
        buf_q[i] <= buf_d[i];
      end
    end
  end

  // ****************************************
  // pending single inserts
  // ****************************************
  // one error per arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bpv_pend_q <= 1'b0;
      exz_pend_q <= 1'b0;
    end else if (ce) begin
      if (bpv_arm) begin
        bpv_pend_q <= 1'b1;
      end else if (step && use_bpv) begin
        bpv_pend_q <= 1'b0;
      end
      if (exz_arm) begin
        exz_pend_q <= 1'b1;
      end else if (step && use_exz) begin
        exz_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // polarity of the emitted symbol
  // ****************************************
  always_comb begin
    out_sym = buf_q[3];
    case (out_sym)
      sym_one: mark = 1'b1;
      sym_cstart: mark = !parity_q;
      sym_viol: mark = 1'b1;
      sym_bpv: mark = 1'b1;
      default: mark = 1'b0;
    endcase
    if (out_sym == sym_viol || out_sym == sym_bpv) begin
      mark_pos = last_pos_q;
    end else begin
      mark_pos = !last_pos_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 1'b0;
      neg <= 1'b0;
      last_pos_q <= 1'b0;
      parity_q <= 1'b0;
    end else if (ce && step) begin
      if (unipolar_mode) begin
        pos <= (out_sym != sym_zero) && (out_sym != sym_held);
        neg <= 1'b0;
      end else begin
        pos <= mark && mark_pos;
        neg <= mark && !mark_pos;
        if (mark) begin
          last_pos_q <= mark_pos;
        end
        if (out_sym == sym_viol) begin
          parity_q <= 1'b0;
        end else if (mark) begin
          parity_q <= !parity_q;
        end
      end
    end
  end

endmodule // bipolar_encoder
`default_nettype wire

// [src/framer_ctrl.sv]
// t3/e3 framer control: loopbacks, alarms, overhead, counter setup, inserts
`timescale 1ns/1ps
`default_nettype none
`include "framer_ctrl_map.svh"

module framer_ctrl
  import framer_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic e3_mode,
  input wire logic cbit_parity_mode,
  input wire logic unipolar_mode,
  input wire line_type line_rx,
  input wire logic line_tx_clock,
  output line_type line_tx,
  output line_type framer_rx,
  input wire logic manual_insert_pin,
  input wire tx_bit_type fmt_in,
  output logic fmt_step,
  input wire tx_bit_type rx_framed,
  input wire logic rx_framed_valid,
  output tx_bit_type rx_payload_out,
  input wire logic febe_error,
  input wire logic hdlc_nat_bit,
  input wire logic feac_nat_bit,
  input wire logic rx_nat_bit,
  output logic nat_bit_to_info,
  output logic nat_bit_to_hdlc,
  output logic nat_bit_to_feac,
  input wire logic lof_active,
  output logic [1:0] frame_err_count_mode,
  output logic frame_err_mode_illegal,
  output logic frame_err_count_enable,
  output logic framed_err_count_enable,
  output logic violation_event
);

  logic [15:0] framer_control_q;
  logic [7:0] error_insert_control_q;
  logic [7:0] eic_prev_q;
  logic [31:0] prdata_q;
  logic hit_fc;
  logic hit_eic;
  logic wr_en;
  logic [2:0] txc_q;
  logic [2:0] rxc_q;
  logic [1:0] rxp_q;
  logic [1:0] rxn_q;
  logic [2:0] man_q;
  logic tx_rise;
  logic rx_rise;
  logic rx_edge;
  logic ais_alt_q;
  logic [1:0] idle_ph_q;
  tx_bit_type rx_framed_q;
  tx_bit_type src;
  logic tx_data;
  logic enc_pos;
  logic enc_neg;
  logic trig_bpv;
  logic trig_exz;
  logic man_rise;
  logic prev_mark_pos_q;
  logic prev_bpv_pos_q;
  logic have_bpv_q;
  logic [2:0] rx_zeros_q;
  logic rx_mark;
  logic rx_same;
  logic rx_is_code;
  logic bpv_now;

  // ****************************************
  // apb register access
  // ****************************************
  assign hit_fc = (paddr == `FRAMER_CONTROL_OFFSET);
  assign hit_eic = (paddr == `ERROR_INSERT_CONTROL_OFFSET);
  assign wr_en = pce && psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_fc && !hit_eic;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      framer_control_q <= `FRAMER_CONTROL_RESET;
      error_insert_control_q <= `ERROR_INSERT_CONTROL_RESET;
    end else if (wr_en) begin
      if (hit_fc) begin
        framer_control_q <= pwdata[15:0] & `FC_WRITABLE_MASK;
      end
      if (hit_eic) begin
        error_insert_control_q <= pwdata[7:0];
      end
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (pce && psel && !penable) begin
      if (hit_fc) begin
        prdata_q <= {16'h0000, framer_control_q};
      end else if (hit_eic) begin
        prdata_q <= {24'h00_0000, error_insert_control_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // pin synchronisers and edge finders
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_q <= 3'h0;
      rxc_q <= 3'h0;
      rxp_q <= 2'h0;
      rxn_q <= 2'h0;
      man_q <= 3'h0;
    end else if (pce) begin
      txc_q <= {txc_q[1:0], line_tx_clock};
      rxc_q <= {rxc_q[1:0], line_rx.clk};
      rxp_q <= {rxp_q[0], line_rx.pos};
      rxn_q <= {rxn_q[0], line_rx.neg};
      man_q <= {man_q[1:0], manual_insert_pin};
    end
  end

  assign tx_rise = txc_q[1] && !txc_q[2];
  assign rx_rise = rxc_q[1] && !rxc_q[2];
  assign man_rise = man_q[1] && !man_q[2];
  assign fmt_step = pce && tx_rise;

  // ****************************************
  // transmit source and overhead
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_framed_q <= '{data: 1'b0, cls: cls_info};
    end else if (pce && rx_framed_valid) begin
      rx_framed_q <= rx_framed;
    end
  end

  // received framed data passes on too
  assign rx_payload_out = rx_framed_q;

  always_comb begin
    if (framer_control_q[`FC_PAYLOAD_LOOP_ENABLE]) begin
      src = rx_framed_q;
    end else begin
      src = fmt_in;
    end
    tx_data = src.data;
    if (framer_control_q[`FC_SEND_ALARM_INDICATION]) begin
      if (e3_mode) begin
        tx_data = 1'b1;
      end else begin
        case (src.cls)
          cls_info: tx_data = ais_alt_q;
          cls_x: tx_data = 1'b1;
          cls_c3, cls_c4, cls_c: tx_data = 1'b0;
          default: tx_data = src.data;
        endcase
      end
    end else if (!e3_mode && framer_control_q[`FC_SEND_IDLE_SIGNAL]) begin
      case (src.cls)
        cls_info: tx_data = !idle_ph_q[1];
        cls_x: tx_data = 1'b1;
        cls_c3: tx_data = 1'b0;
        default: tx_data = src.data;
      endcase
    end else if (!framer_control_q[`FC_TRANSPARENT_PASS_THROUGH]) begin
      // overhead only when not passing through
      case (src.cls)
        cls_x: begin
          if (!e3_mode) begin
            tx_data = !framer_control_q[`FC_SEND_REMOTE_ALARM];
          end
        end
        cls_rai: begin
          if (e3_mode) begin
            tx_data = framer_control_q[`FC_SEND_REMOTE_ALARM];
          end
        end
        cls_nat: begin
          if (e3_mode) begin
            case (framer_control_q[`FC_NATIONAL_BIT_SOURCE_HI:
                                   `FC_NATIONAL_BIT_SOURCE_LO])
              `NAT_FORCE_ONE: tx_data = 1'b1;
              `NAT_FROM_HDLC: tx_data = hdlc_nat_bit;
              `NAT_FROM_FEAC: tx_data = feac_nat_bit;
              default: tx_data = 1'b0;
            endcase
          end
        end
        cls_c4: begin
          if (!e3_mode && cbit_parity_mode) begin
            if (framer_control_q[`FC_AUTO_BLOCK_ERROR_DEFEAT]) begin
              tx_data = !framer_control_q[`FC_MANUAL_BLOCK_ERROR_VALUE];
            end else begin
              tx_data = !febe_error;
            end
          end
        end
        default: tx_data = src.data;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ais_alt_q <= 1'b1;
      idle_ph_q <= 2'h0;
    end else if (pce && tx_rise && src.cls == cls_info) begin
      ais_alt_q <= !ais_alt_q;
      idle_ph_q <= idle_ph_q + 2'h1;
    end
  end

  // ****************************************
  // error insert triggers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eic_prev_q <= `ERROR_INSERT_CONTROL_RESET;
    end else if (pce) begin
      eic_prev_q <= error_insert_control_q;
    end
  end

  always_comb begin
    if (error_insert_control_q[`EI_MANUAL_INSERT_MODE]) begin
      trig_bpv = man_rise &&
                 error_insert_control_q[`EI_BIPOLAR_VIOLATION_INSERT];
      trig_exz = man_rise && error_insert_control_q[`EI_EXCESS_ZERO_INSERT];
    end else begin
      trig_bpv = error_insert_control_q[`EI_BIPOLAR_VIOLATION_INSERT] &&
                 !eic_prev_q[`EI_BIPOLAR_VIOLATION_INSERT];
      trig_exz = error_insert_control_q[`EI_EXCESS_ZERO_INSERT] &&
                 !eic_prev_q[`EI_EXCESS_ZERO_INSERT];
    end
  end

  bipolar_encoder u_encoder (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pce),
    .step(tx_rise),
    .data(tx_data),
    .e3_mode(e3_mode),
    .unipolar_mode(unipolar_mode),
    .bpv_arm(trig_bpv && !unipolar_mode),
    .exz_arm(trig_exz && !unipolar_mode),
    .pos(enc_pos),
    .neg(enc_neg)
  );

  // ****************************************
  // loopback steering
  // ****************************************
  always_comb begin
    if (framer_control_q[`FC_LINE_LOOP_ENABLE]) begin
      line_tx = '{clk: rxc_q[1], pos: rxp_q[1], neg: rxn_q[1]};
    end else begin
      line_tx = '{clk: txc_q[1], pos: enc_pos, neg: enc_neg};
    end
    if (framer_control_q[`FC_DIAG_LOOP_ENABLE]) begin
      framer_rx = '{clk: txc_q[1], pos: enc_pos, neg: enc_neg};
      rx_edge = tx_rise;
    end else begin
      framer_rx = '{clk: rxc_q[1], pos: rxp_q[1], neg: rxn_q[1]};
      rx_edge = rx_rise;
    end
  end

  // ****************************************
  // receive violation detection
  // ****************************************
  assign rx_mark = framer_rx.pos || framer_rx.neg;
  assign rx_same = rx_mark && (framer_rx.pos == prev_mark_pos_q);
  // substitution violations follow a zero run
  assign rx_is_code = e3_mode ? (rx_zeros_q >= 3'd2) : (rx_zeros_q >= 3'd1);
  assign bpv_now = rx_same && !rx_is_code;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_mark_pos_q <= 1'b0;
      prev_bpv_pos_q <= 1'b0;
      have_bpv_q <= 1'b0;
      rx_zeros_q <= 3'h7;
      violation_event <= 1'b0;
    end else if (pce) begin
      violation_event <= 1'b0;
      if (rx_edge && !unipolar_mode) begin
        if (rx_mark) begin
          prev_mark_pos_q <= framer_rx.pos;
          rx_zeros_q <= 3'h0;
        end else if (rx_zeros_q != 3'h7) begin
          rx_zeros_q <= rx_zeros_q + 3'h1;
        end
        if (bpv_now) begin
          have_bpv_q <= 1'b1;
          prev_bpv_pos_q <= framer_rx.pos;
          if (e3_mode && framer_control_q[`FC_CODE_VIOLATION_COUNT_SEL]) begin
            violation_event <= have_bpv_q &&
                               (prev_bpv_pos_q == framer_rx.pos);
          end else begin
            violation_event <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // national bit fan-out and counter setup
  // ****************************************
  // national bit always delivered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nat_bit_to_info <= 1'b0;
      nat_bit_to_hdlc <= 1'b0;
      nat_bit_to_feac <= 1'b0;
    end else if (pce) begin
      nat_bit_to_info <= rx_nat_bit;
      nat_bit_to_hdlc <= rx_nat_bit;
      nat_bit_to_feac <= rx_nat_bit;
    end
  end

  assign frame_err_count_mode =
    framer_control_q[`FC_FRAME_ERR_COUNT_SEL_HI:`FC_FRAME_ERR_COUNT_SEL_LO];
  assign frame_err_mode_illegal =
    e3_mode && (frame_err_count_mode == `FE_COUNT_ILLEGAL_E3);
  assign framed_err_count_enable =
    !lof_active || framer_control_q[`FC_COUNT_DURING_LOF];
  assign frame_err_count_enable =
    (frame_err_count_mode == `FE_COUNT_LOF) || framed_err_count_enable;

endmodule // framer_ctrl
`default_nettype wire

// [tb/framer_ctrl_checker.sv]
// port assertions for the framer control block
`timescale 1ns/1ps
`default_nettype none
module framer_ctrl_checker
  import framer_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic e3_mode,
  input wire line_type line_rx,
  input wire line_type line_tx,
  input wire line_type framer_rx,
  input wire tx_bit_type rx_framed,
  input wire logic rx_framed_valid,
  input wire tx_bit_type rx_payload_out,
  input wire logic rx_nat_bit,
  input wire logic nat_bit_to_info,
  input wire logic nat_bit_to_hdlc,
  input wire logic nat_bit_to_feac,
  input wire logic lof_active,
  input wire logic [1:0] frame_err_count_mode,
  input wire logic frame_err_mode_illegal,
  input wire logic framed_err_count_enable
);
  logic [15:0] ctl_q;
  // ****
  // shadow of framer_control
  // ****
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 16'h0000;
    end else if (psel && penable && pwrite && pce && paddr == 8'h10) begin
      ctl_q <= pwdata[15:0] & 16'h7fff;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_ctl_s;
    psel && !penable && pce && paddr == 8'h10 ##1 psel && penable;
  endsequence
  chk_ctl_readback: assert property (
    rd_ctl_s |-> prdata == {16'h0000, $past(ctl_q)}) else $error("readback");
  chk_nat_route: assert property ($past(presetn) && $past(pce) |->
    {nat_bit_to_info, nat_bit_to_hdlc, nat_bit_to_feac}
    == {3{$past(rx_nat_bit)}}) else $error("nat route");
  chk_fe_mode: assert property (
    frame_err_count_mode == ctl_q[10:9]) else $error("fe mode");
  chk_fe_illegal: assert property (frame_err_mode_illegal ==
    (e3_mode && frame_err_count_mode == 2'b11)) else $error("fe illegal");
  chk_lof_gate: assert property (
    framed_err_count_enable == (!lof_active || ctl_q[11]))
    else $error("lof gate");
  chk_line_loop: assert property (ctl_q[6] && !ctl_q[7] && !ctl_q[0] &&
    $past(ctl_q[6], 2) && $past(pce) && $past(pce, 2)
    |-> line_tx == $past(line_rx, 2)) else $error("line loop");
  chk_diag_loop: assert property (ctl_q[7] && !ctl_q[6] && !ctl_q[0]
    |-> {framer_rx.pos, framer_rx.neg} == {line_tx.pos, line_tx.neg})
    else $error("diag loop");
  chk_payload_copy: assert property ($past(presetn) && $past(pce) &&
    $past(rx_framed_valid) |-> rx_payload_out == $past(rx_framed))
    else $error("payload copy");
endmodule // framer_ctrl_checker
bind framer_ctrl framer_ctrl_checker framer_ctrl_checker_i (.*);
`default_nettype wire

// [tb/line_partner.sv]
// line side model: transmit clock and a receive mark stream
`timescale 1ns/1ps
`default_nettype none
module line_partner
  import framer_ctrl_pkg::*;
(
  output logic line_tx_clock,
  output line_type line_rx
);
  logic [3:0] cnt;
  // ****
  // free running line clock, off the pclk grid
  // ****
  initial begin
    line_tx_clock = 1'b0;
    line_rx = '0;
    cnt = 4'h0;
    #1.3;
    forever begin
      #62.5;
      line_tx_clock = ~line_tx_clock;
      line_rx.clk = line_tx_clock;
      cnt = cnt + 4'h1;
      line_rx.pos = cnt[1] & cnt[3];
      line_rx.neg = cnt[1] & ~cnt[3];
    end
  end
endmodule // line_partner
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the framer control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) total_checks++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end
module tb_top
  import framer_ctrl_pkg::*;
;
  logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic e3_mode, unipolar_mode, cbit_parity_mode, manual_insert_pin;
  logic line_tx_clock, fmt_step, rx_framed_valid, febe_error, lof_active;
  logic hdlc_nat_bit, feac_nat_bit, rx_nat_bit, nat_bit_to_info;
  logic nat_bit_to_hdlc, nat_bit_to_feac, frame_err_mode_illegal;
  logic frame_err_count_enable, framed_err_count_enable, violation_event;
  logic [1:0] frame_err_count_mode;
  line_type line_rx, line_tx, framer_rx;
  tx_bit_type fmt_in, rx_framed, rx_payload_out;
  int fails, total_checks, nv;
  logic [3:0] txv;
  framer_ctrl framer_ctrl_i (.*);
  line_partner line_partner_i (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (fmt_step === 1'b1) begin
      fmt_in.data <= ~fmt_in.data;
    end
  end
  task automatic guard(input logic bad);
    if (bad) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    guard(pready !== 1'b1);
    @(posedge pclk);
  endtask
  task automatic wait_step();
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (fmt_step !== 1'b1 && k < 40);
    guard(fmt_step !== 1'b1);
  endtask
  task automatic t_regs();
    apb(0, 8'h18, 0);
    `CHK("eic reset", 32'h0, rdv)
    apb(1, 8'h10, 32'hffff);
    apb(0, 8'h10, 0);
    `CHK("ctl rw", 32'h7fff, rdv)
    apb(1, 8'h18, 32'hffff);
    apb(0, 8'h18, 0);
    `CHK("eic rw", 32'hff, rdv)
    apb(0, 8'h14, 0);
    `CHK("unmapped", 33'h100000000, {slv, rdv})
    pce <= 1'b0;
    apb(1, 8'h10, 1);
    pce <= 1'b1;
    apb(0, 8'h10, 0);
    `CHK("frozen", 32'h7fff, rdv)
    apb(1, 8'h18, 0);
  endtask
  task automatic t_nat();
    apb(1, 8'h10, 32'h18);
    rx_nat_bit <= 1'b1;
    hdlc_nat_bit <= 1'b1;
    feac_nat_bit <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("nat", 3'h7, {nat_bit_to_info, nat_bit_to_hdlc, nat_bit_to_feac})
    rx_nat_bit <= 1'b0;
  endtask
  task automatic t_count();
    logic [1:0] m;
    e3_mode <= 1'b1;
    lof_active <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      apb(1, 8'h10, {20'h0, m[0], m, 9'h0});
      `CHK("fe mode", m, frame_err_count_mode)
      `CHK("fe bad", m == 2'b11, frame_err_mode_illegal)
      `CHK("fe gate", m == 2'b00 || m[0], frame_err_count_enable)
      `CHK("lof gate", m[0], framed_err_count_enable)
    end
    lof_active <= 1'b0;
  endtask
  task automatic t_ais();
    logic p;
    apb(1, 8'h10, 32'h23);
    repeat (8) wait_step();
    @(posedge pclk);
    p = line_tx.pos;
    for (int i = 0; i < 8; i++) begin
      wait_step();
      @(posedge pclk);
      `CHK("ais mark", 1'b1, line_tx.pos ^ line_tx.neg)
      `CHK("ais alt", ~p, line_tx.pos)
      p = line_tx.pos;
    end
    e3_mode <= 1'b0;
  endtask
  task automatic t_loops();
    apb(1, 8'h10, 32'h40);
    repeat (40) @(posedge pclk);
    apb(1, 8'h10, 32'h80);
    repeat (40) @(posedge pclk);
    apb(1, 8'h10, 32'h4000);
    rx_framed <= '{1'b1, cls_m};
    rx_framed_valid <= 1'b1;
    @(posedge pclk);
    rx_framed_valid <= 1'b0;
    @(posedge pclk);
    `CHK("payload", rx_framed, rx_payload_out)
    apb(1, 8'h10, 0);
  endtask
  task automatic tx_out(input int c, input bit_class_type k);
    fmt_in.cls <= k;
    apb(1, 8'h10, c);
    repeat (5) wait_step();
    for (int i = 0; i < 4; i++) begin
      wait_step();
      @(posedge pclk);
      txv = {txv[2:0], line_tx.pos};
    end
  endtask
  task automatic count_viol();
    nv = 0;
    repeat (300) begin
      @(posedge pclk);
      nv += (violation_event === 1'b1);
    end
  endtask
  task automatic t_tx();
    unipolar_mode <= 1'b1;
    tx_out(32'h2, cls_x);
    `CHK("x rai", 4'h0, txv)
    tx_out(32'h0, cls_x);
    `CHK("x clear", 4'hf, txv)
    tx_out(32'h3, cls_c);
    `CHK("ais c", 4'h0, txv)
    tx_out(32'h3, cls_info);
    `CHK("ais info", 1'b1, txv == 4'ha || txv == 4'h5)
    tx_out(32'h22, cls_x);
    `CHK("idle x", 4'hf, txv)
    tx_out(32'h20, cls_c3);
    `CHK("idle c3", 4'h0, txv)
    tx_out(32'h20, cls_info);
    `CHK("idle info", 1'b1, (txv[3] ^ txv[1]) & (txv[2] ^ txv[0]))
    tx_out(32'h6, cls_x);
    `CHK("pass x", 1'b1, txv == 4'ha || txv == 4'h5)
    cbit_parity_mode <= 1'b1;
    febe_error <= 1'b1;
    tx_out(32'h0, cls_c4);
    `CHK("febe auto", 4'h0, txv)
    tx_out(32'h1000, cls_c4);
    `CHK("febe null", 4'hf, txv)
    tx_out(32'h3000, cls_c4);
    `CHK("febe set", 4'h0, txv)
    tx_out(32'h4000, cls_info);
    `CHK("plb tx", 4'hf, txv)
    e3_mode <= 1'b1;
    tx_out(32'h2, cls_rai);
    `CHK("e3 rai", 4'hf, txv)
    tx_out(32'h18, cls_nat);
    `CHK("nat zero", 4'h0, txv)
    tx_out(32'h8, cls_nat);
    `CHK("nat hdlc", 4'hf, txv)
    tx_out(32'h1, cls_c);
    `CHK("e3 ais", 4'hf, txv)
    {unipolar_mode, cbit_parity_mode, febe_error} <= 3'h0;
  endtask
  task automatic t_insert();
    e3_mode <= 1'b1;
    apb(1, 8'h10, 32'h81);
    repeat (8) wait_step();
    apb(1, 8'h18, 1);
    count_viol();
    `CHK("bpv one", 1, nv)
    apb(1, 8'h18, 1);
    count_viol();
    `CHK("bpv held", 0, nv)
    apb(1, 8'h18, 32'h81);
    manual_insert_pin <= 1'b1;
    count_viol();
    `CHK("bpv pin", 1, nv)
    manual_insert_pin <= 1'b0;
    apb(1, 8'h18, 0);
    apb(1, 8'h10, 0);
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {presetn, pce, psel, penable, pwrite, paddr, pwdata} = '0;
    {e3_mode, unipolar_mode, cbit_parity_mode, manual_insert_pin} = '0;
    {rx_framed_valid, febe_error, hdlc_nat_bit, feac_nat_bit} = '0;
    {rx_nat_bit, lof_active, fmt_in, rx_framed} = '0;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    pce <= 1'b1;
    t_regs();
    t_nat();
    t_count();
    t_ais();
    t_loops();
    t_tx();
    t_insert();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
